// file: rtl/btc_top.sv
// Purpose: Trace trigger and capture for a monitored processor bus.
// Assumes: Bus cycle inputs are synchronous to pclk, one per bus_valid.
// Notes:   Registers are reached over APB with one wait state.
//
// Function
// - Arming covers only the next program run, then expires.
// - A new setup discards the previous trigger set, mode and capture.
// - Trigger addresses outside D000..FFFF are rejected.
// - Up to 8 trigger entries; a match on any is a trigger.
// - A range matches all addresses between bounds; hi must exceed lo.
// - After mode records from the trigger for at most 8192 cycles.
// - After mode raises NMI when the buffer fills.
// - After mode keeps recorded cycles if the run ends early.
// - After mode with no trigger leaves the buffer empty.
// - After a triggered stop the offset points at the trigger entry.
// - N is 1..4096, default 1.
// - Before mode records the last 8192 cycles, stops with NMI on Nth hit.
// - Before mode without Nth hit keeps data, offset at buffer end.
// - While armed, breakpoints are withheld and single step refused.
// - Readback starts at the offset, stops at end or count, advances.
// - Each entry is 32 bits: address, data, tests, mark and rw.
// - Mark is set only on the first cycle of each instruction.
//
// Local design decisions: the address map and register access over APB.
module btc_top
    import btc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        run_active,
    input  wire logic        bus_valid,
    output logic             bus_ready,
    input  wire logic [15:0] bus_addr,
    input  wire logic [7:0]  bus_data,
    input  wire logic        bus_rw,
    input  wire logic        bus_lir,
    input  wire logic [5:0]  test_pts,
    input  wire logic        resume_single_step,
    input  wire logic        step_until_address,
    output logic             nmi_req,
    output logic             trace_armed,
    output logic             step_refused
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    btc_state_t  state_r;
    btc_mode_t   mode_r;
    btc_trig_t   trig_r [TRIG_SLOTS];
    logic [3:0]  slots_r;
    logic [12:0] n_r;
    logic [12:0] hits_r;
    logic        reject_r;
    logic        run_prev_r;
    logic        trig_seen_r;
    logic        stop_r;
    logic        nmi_r;
    logic        armed_r;
    logic        refuse_r;
    logic [13:0] count_r;
    logic [12:0] wr_ptr_r;
    logic [13:0] tofs_r;
    logic [13:0] rleft_r;
    logic [31:0] mem_r [8192];
    logic [31:0] mem_q_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] rd_mux;

    btc_entry_t  in_e;
    btc_entry_t  f_e;
    logic        f_valid;
    logic        f_ready;
    logic        in_valid;
    logic        bus_ready_w;

    logic        acc;
    logic        wr_ev;
    logic        rd_ev;
    logic        setup_ev;
    logic        pop;
    logic        cap;
    logic        hit;
    logic        aft_start;
    logic        aft_rec;
    logic        bef_rec;
    logic        wr_mem;
    logic        nth;
    logic        stop_ev;
    logic        run_end;
    logic        rd_ok;
    logic [13:0] new_idx;
    logic [12:0] oldest;
    logic [12:0] rd_phys;
    logic        one_ok;
    logic        rng_ok;

    ////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic in_window(input logic [15:0] a);
        in_window = (a >= WIN_LO) && (a <= WIN_HI);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_CTRL) || (a == OFS_NCOUNT) ||
                 (a == OFS_TONE) || (a == OFS_TRANGE) ||
                 (a == OFS_STATUS) || (a == OFS_TOFS) ||
                 (a == OFS_RDATA) || (a == OFS_RCOUNT) ||
                 (a == OFS_LEVEL);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    assign acc      = psel && penable;
    assign wr_ev    = acc && pready_r && pwrite;
    assign rd_ev    = acc && pready_r && !pwrite;
    assign setup_ev = wr_ev && (paddr == OFS_CTRL);

    // Candidate trigger entries
    assign one_ok = in_window(pwdata[15:0]) && (slots_r != SLOT_MAX);
    assign rng_ok = in_window(pwdata[15:0]) &&
                    in_window(pwdata[31:16]) &&
                    (pwdata[31:16] > pwdata[15:0]) &&
                    (slots_r != SLOT_MAX);

    ////////////////////////////////////////////////////////////////////////
    // Capture path: bus cycle into the two-entry buffer
    always_comb begin
        in_e      = '0;
        in_e.addr = bus_addr;
        in_e.data = bus_data;
        in_e.rw   = bus_rw;
        in_e.mark = bus_lir;
        in_e.tp   = test_pts;
    end

    assign in_valid = bus_valid && (state_r == ST_RUN) && !stop_r;
    // Buffer RAM port is shared with data readback
    assign f_ready  = !(psel && (paddr == OFS_RDATA));

    btc_fifo2 #(
        .W     (32),
        .DEPTH (2)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (in_valid),
        .in_data   (in_e),
        .in_ready  (bus_ready_w),
        .out_valid (f_valid),
        .out_data  (f_e),
        .out_ready (f_ready)
    );

    // Trigger match over all slots, fetch cycles only
    always_comb begin
        hit = 1'b0;
        for (int i = 0; i < TRIG_SLOTS; i++) begin
            if (trig_r[i].used && f_e.addr >= trig_r[i].lo &&
                f_e.addr <= trig_r[i].hi) begin
                hit = 1'b1;
            end
        end
        hit = hit && f_e.mark;
    end

    // Capture decisions for one drained entry
    assign pop       = f_valid && f_ready;
    assign cap       = pop && (state_r == ST_RUN) && !stop_r;
    assign aft_start = cap && (mode_r == MODE_AFTER) && !trig_seen_r
                       && hit;
    assign aft_rec   = cap && (mode_r == MODE_AFTER) && trig_seen_r;
    assign bef_rec   = cap && (mode_r == MODE_BEFORE);
    assign wr_mem    = aft_start || aft_rec || bef_rec;
    assign nth       = bef_rec && hit && ((hits_r + 1'b1) == n_r);
    assign stop_ev   = nth || (aft_rec && count_r == BUF_FULL - 1'b1);
    assign run_end   = (state_r == ST_RUN) && !run_active;
    assign new_idx   = (count_r == BUF_FULL) ? BUF_FULL - 1'b1 : count_r;

    // Readback addressing, oldest entry first
    assign oldest  = (count_r == BUF_FULL) ? wr_ptr_r : '0;
    assign rd_phys = oldest + tofs_r[12:0];
    assign rd_ok   = (tofs_r < count_r) && (rleft_r != '0);

    ////////////////////////////////////////////////////////////////////////
    // Run state: arm, run, done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= ST_IDLE;
            run_prev_r <= 1'b0;
        end else begin
            run_prev_r <= run_active;
            if (setup_ev) begin
                state_r <= ST_ARMED;
            end else begin
                case (state_r)
                    ST_IDLE: state_r <= ST_IDLE;
                    ST_ARMED: begin
                        if (run_active && !run_prev_r) begin
                            state_r <= ST_RUN;
                        end
                    end
                    ST_RUN: begin
                        if (!run_active) begin
                            state_r <= ST_DONE;
                        end
                    end
                    ST_DONE: state_r <= ST_DONE;
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // Setup: mode, trigger slots, execution count, reject flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r   <= MODE_AFTER;
            slots_r  <= '0;
            n_r      <= N_RST;
            reject_r <= 1'b0;
            for (int i = 0; i < TRIG_SLOTS; i++) begin
                trig_r[i] <= '0;
            end
        end else begin
            if (setup_ev) begin
                mode_r  <= btc_mode_t'(pwdata[CTRL_MODE]);
                slots_r <= '0;
                n_r     <= N_RST;
                for (int i = 0; i < TRIG_SLOTS; i++) begin
                    trig_r[i] <= '0;
                end
            end
            if (wr_ev && paddr == OFS_TONE && one_ok) begin
                trig_r[slots_r[2:0]] <= {1'b1, pwdata[15:0], pwdata[15:0]};
                slots_r <= slots_r + 1'b1;
            end
            if (wr_ev && paddr == OFS_TRANGE && rng_ok) begin
                trig_r[slots_r[2:0]] <= {1'b1, pwdata[15:0], pwdata[31:16]};
                slots_r <= slots_r + 1'b1;
            end
            if (wr_ev && paddr == OFS_NCOUNT && pwdata[31:13] == '0 &&
                pwdata[12:0] >= N_MIN && pwdata[12:0] <= N_MAX) begin
                n_r <= pwdata[12:0];
            end
            // Sticky reject; a new reject wins over the clear
            if ((wr_ev && paddr == OFS_TONE && !one_ok) ||
                (wr_ev && paddr == OFS_TRANGE && !rng_ok) ||
                (wr_ev && paddr == OFS_NCOUNT &&
                 (pwdata[31:13] != '0 || pwdata[12:0] < N_MIN ||
                  pwdata[12:0] > N_MAX))) begin
                reject_r <= 1'b1;
            end else if (wr_ev && paddr == OFS_STATUS &&
                         pwdata[STS_REJECT]) begin
                reject_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture bookkeeping: count, write pointer, hits, stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r     <= '0;
            wr_ptr_r    <= '0;
            hits_r      <= '0;
            trig_seen_r <= 1'b0;
            stop_r      <= 1'b0;
        end else if (setup_ev) begin
            count_r     <= '0;
            wr_ptr_r    <= '0;
            hits_r      <= '0;
            trig_seen_r <= 1'b0;
            stop_r      <= 1'b0;
        end else begin
            if (aft_start) begin
                count_r     <= 14'h0001;
                wr_ptr_r    <= 13'h0001;
                trig_seen_r <= 1'b1;
            end else if (wr_mem) begin
                if (count_r != BUF_FULL) begin
                    count_r <= count_r + 1'b1;
                end
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (bef_rec && hit) begin
                hits_r <= hits_r + 1'b1;
            end
            if (stop_ev) begin
                stop_r <= 1'b1;
            end
        end
    end

    // Buffer RAM: capture write, readback fetch in the setup cycle
    always_ff @(posedge pclk) begin
        if (wr_mem) begin
            mem_r[aft_start ? 13'h0000 : wr_ptr_r] <= f_e;
        end
        if (psel && !penable) begin
            mem_q_r <= mem_r[rd_phys];
        end
    end

    // Trigger offset pointer and readback count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tofs_r  <= '0;
            rleft_r <= RCNT_RST;
        end else begin
            if (setup_ev) begin
                tofs_r <= '0;
            end else if (aft_start) begin
                tofs_r <= '0;
            end else if (nth) begin
                tofs_r <= new_idx;
            end else if (run_end && mode_r == MODE_BEFORE && !stop_r) begin
                tofs_r <= wr_mem ? new_idx
                        : ((count_r == '0) ? '0 : count_r - 1'b1);
            end else if (wr_ev && paddr == OFS_TOFS) begin
                tofs_r <= pwdata[13:0];
            end else if (rd_ev && paddr == OFS_RDATA && rd_ok) begin
                tofs_r <= tofs_r + 1'b1;
            end
            if (wr_ev && paddr == OFS_RCOUNT) begin
                rleft_r <= pwdata[13:0];
            end else if (rd_ev && paddr == OFS_RDATA && rd_ok) begin
                rleft_r <= rleft_r - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // NMI, armed indication, step refusal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_r    <= 1'b0;
            armed_r  <= 1'b0;
            refuse_r <= 1'b0;
        end else begin
            // Held until the monitor has regained control
            if (stop_ev) begin
                nmi_r <= 1'b1;
            end else if (!run_active || setup_ev) begin
                nmi_r <= 1'b0;
            end
            armed_r  <= (state_r == ST_ARMED) || (state_r == ST_RUN)
                        || setup_ev;
            refuse_r <= armed_r &&
                        (resume_single_step || step_until_address);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read mux
    always_comb begin
        rd_mux = '0;
        case (paddr)
            OFS_CTRL:   rd_mux[CTRL_MODE] = mode_r;
            OFS_NCOUNT: rd_mux[12:0] = n_r;
            OFS_TONE:   rd_mux[3:0] = slots_r;
            OFS_TRANGE: rd_mux[3:0] = slots_r;
            OFS_STATUS: begin
                rd_mux[STS_ARMED]  = armed_r;
                rd_mux[STS_RUN]    = (state_r == ST_RUN);
                rd_mux[STS_TRIG]   = stop_r || trig_seen_r;
                rd_mux[STS_FULL]   = (count_r == BUF_FULL);
                rd_mux[STS_EMPTY]  = (count_r == '0);
                rd_mux[STS_REJECT] = reject_r;
                rd_mux[STS_NMI]    = nmi_r;
                rd_mux[STS_RDEND]  = !rd_ok;
            end
            OFS_TOFS:   rd_mux[13:0] = tofs_r;
            OFS_RDATA:  rd_mux = rd_ok ? mem_q_r : '0;
            OFS_RCOUNT: rd_mux[13:0] = rleft_r;
            OFS_LEVEL:  rd_mux[13:0] = count_r;
            default:    rd_mux = '0;
        endcase
    end

    // APB answer: one wait state on every access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= acc && !pready_r;
            pslverr_r <= acc && !pready_r && !mapped(paddr);
            if (acc && !pready_r && !pwrite) begin
                prdata_r <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign bus_ready    = bus_ready_w;
    assign nmi_req      = nmi_r;
    assign trace_armed  = armed_r;
    assign step_refused = refuse_r;

endmodule

// file: rtl/btc_pkg.sv
// Purpose: Shared constants and types for the bus trace trigger capture.
// Assumes: 32-bit APB, byte addresses, one word per register.
// Notes:   Capture entries are one packed word per monitored bus cycle.
package btc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Buffer geometry
    localparam int          BUF_AW   = 13;
    localparam logic [13:0] BUF_FULL = 14'h2000;   // 8192 entries
    localparam int          TRIG_SLOTS = 8;
    localparam logic [3:0]  SLOT_MAX = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_NCOUNT = 8'h04;
    localparam logic [7:0] OFS_TONE   = 8'h08;
    localparam logic [7:0] OFS_TRANGE = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_TOFS   = 8'h14;
    localparam logic [7:0] OFS_RDATA  = 8'h18;
    localparam logic [7:0] OFS_RCOUNT = 8'h1c;
    localparam logic [7:0] OFS_LEVEL  = 8'h20;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTRL_MODE   = 0;
    localparam int STS_ARMED   = 0;
    localparam int STS_RUN     = 1;
    localparam int STS_TRIG    = 2;
    localparam int STS_FULL    = 3;
    localparam int STS_EMPTY   = 4;
    localparam int STS_REJECT  = 5;
    localparam int STS_NMI     = 6;
    localparam int STS_RDEND   = 7;

    ////////////////////////////////////////////////////////////////////////
    // Limits and reset values
    localparam logic [15:0] WIN_LO   = 16'hd000;
    localparam logic [15:0] WIN_HI   = 16'hffff;
    localparam logic [12:0] N_MIN    = 13'h0001;
    localparam logic [12:0] N_MAX    = 13'h1000;   // 4096
    localparam logic [12:0] N_RST    = 13'h0001;
    localparam logic [13:0] RCNT_RST = 14'h0001;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic [5:0]  tp;
        logic        mark;
        logic        rw;
        logic [7:0]  data;
        logic [15:0] addr;
    } btc_entry_t;

    typedef struct packed {
        logic        used;
        logic [15:0] lo;
        logic [15:0] hi;
    } btc_trig_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_DONE  = 4'b1000
    } btc_state_t;

    typedef enum logic {
        MODE_AFTER  = 1'b0,
        MODE_BEFORE = 1'b1
    } btc_mode_t;

endpackage

// file: rtl/btc_fifo2.sv
// Purpose: Small valid/ready buffer in the capture data path.
// Assumes: DEPTH is a power of two.
// Notes:   Input ready is registered so it can leave the block directly.
module btc_fifo2
    import btc_pkg::*;
#(
    parameter int W     = 32,
    parameter int DEPTH = 2
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);

    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0]   cnt_r;
    logic [PW:0]   cnt_nxt;
    logic          ready_r;
    logic          push;
    logic          pop;

    ////////////////////////////////////////////////////////////////////////
    // Handshake terms
    assign push      = in_valid && ready_r;
    assign pop       = out_valid && out_ready;
    assign in_ready  = ready_r;
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];

    // Occupancy after this edge
    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // Pointers, count and registered ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_r    <= '0;
            rp_r    <= '0;
            cnt_r   <= '0;
            ready_r <= 1'b1;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r   <= cnt_nxt;
            ready_r <= (cnt_nxt != (PW+1)'(DEPTH));
        end
    end

    // Storage
    always_ff @(posedge pclk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

endmodule

// file: sim/btc_top_monitor.sv
// Purpose: Port checks for the trace capture block.
// Assumes: One APB wait state; step pulse one cycle after a request.
// Notes:   Bound onto every btc_top below.
module btc_top_monitor (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       run_active,
    input wire logic       resume_single_step,
    input wire logic       step_until_address,
    input wire logic       nmi_req,
    input wire logic       trace_armed,
    input wire logic       step_refused
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_wait; psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_wait: assert property (p_wait) else $error("bad wait state");
    property p_err;
        pslverr |-> pready && (paddr > 8'h20 || paddr[1:0] != 2'b00);
    endproperty
    a_err: assert property (p_err) else $error("stray slave error");
    property p_step; (resume_single_step || step_until_address)
        && trace_armed |=> step_refused; endproperty
    a_step: assert property (p_step) else $error("step let in");
    property p_src; step_refused |-> $past(trace_armed)
        && ($past(resume_single_step) || $past(step_until_address));
    endproperty
    a_src: assert property (p_src) else $error("stray refusal");
    property p_nclr; !run_active [*2] |-> !nmi_req; endproperty
    a_nclr: assert property (p_nclr) else $error("nmi held");
    property p_nrun; $rose(nmi_req) |-> $past(run_active); endproperty
    a_nrun: assert property (p_nrun) else $error("nmi off run");
    property p_exp; $fell(run_active) |-> ##[1:2] !trace_armed; endproperty
    a_exp: assert property (p_exp) else $error("arming kept");
    property p_rst; $rose(presetn) |-> !trace_armed && !nmi_req;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind btc_top btc_top_monitor u_btc_top_monitor (.*);

// file: sim/btc_bus_model.sv
// Purpose: Monitored processor bus: fetch and operand cycles in a loop.
// Assumes: Fetches at e000..e00e, operands always at e100.
// Notes:   cnt counts cycles taken from the first fetch at trig.
module btc_bus_model
    import btc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        go,
    input  wire logic        bus_ready,
    input  wire logic [15:0] trig,
    output logic             run_active,
    output logic             bus_valid,
    output btc_entry_t       ent,
    output btc_entry_t       first,
    output int               cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] k;
    initial {run_active, bus_valid, ent, k, cnt} = '0;
    // Cycle held until taken; released lines show the inverse
    always @(posedge pclk) begin
        run_active <= go;
        if (go && !run_active) begin
            cnt <= 0;
            k <= '0;
        end
        if (!bus_valid || bus_ready) begin
            bus_valid <= go && run_active;
            if (go && run_active) begin
                k <= k + 4'h1;
                ent.tp <= 6'($urandom);
                ent.mark <= !k[0];
                ent.rw <= k[0] ? 1'($urandom) : 1'b1;
                ent.data <= 8'($urandom);
                ent.addr <= k[0] ? 16'he100 : {12'he00, k[3:1], 1'b0};
            end else begin
                ent <= ~ent;
            end
        end
        if (bus_valid && bus_ready
            && (cnt > 0 || ent.addr == trig && ent.mark)) begin
            if (cnt == 0)
                first <= ent;
            cnt <= cnt + 1;
        end
    end
endmodule

// file: sim/btc_top_test.sv
// Purpose: Self-checking bench for the trace trigger capture block.
// Assumes: The bus model stands for the monitored processor.
// Notes:   Step requests arrive at random throughout.
module btc_top_test
    import btc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, bus_ready, nmi_req, trace_armed, er;
    logic        step_refused, run_active, bus_valid, go = 0;
    logic        resume_single_step = 0, step_until_address = 0;
    logic [15:0] trig = '0;
    btc_entry_t  ent, first;
    int          cnt, lv, fail_count = 0, checked = 0;
    logic [7:0]  ba [4] = '{OFS_TONE, OFS_TRANGE, OFS_NCOUNT, OFS_NCOUNT};
    logic [31:0] bd [4] = '{32'hcfff, 32'he000e000, 32'h0, 32'h1001};
    btc_top u_btc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .run_active, .bus_valid,
        .bus_ready, .bus_addr(ent.addr), .bus_data(ent.data),
        .bus_rw(ent.rw), .bus_lir(ent.mark), .test_pts(ent.tp),
        .resume_single_step, .step_until_address, .nmi_req,
        .trace_armed, .step_refused);
    btc_bus_model u_btc_bus_model (.pclk, .go, .bus_ready, .trig,
        .run_active, .bus_valid, .ent, .first, .cnt);
    // Clock and random step requests
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        resume_single_step <= ($urandom_range(15) == 0);
        step_until_address <= ($urandom_range(15) == 1);
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        chk(rd, e);
    endtask
    task automatic setup(input btc_mode_t m, input logic [15:0] t);
        trig <= t;
        apb(1'b1, OFS_CTRL, {31'h0, m});
        apb(1'b1, OFS_TONE, {16'h0, t});
    endtask
    task automatic run(input int n);
        go <= 1'b1;
        for (int i = 0; i < n && nmi_req !== 1'b1; i++) @(posedge pclk);
        go <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    task automatic at_end;
        apb(1'b0, OFS_LEVEL, '0);
        rc(OFS_TOFS, rd - 32'h1);
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard
    initial begin
        #300us;
        fail_count++;
        print_verdict();
    end
    // Main sequence
    initial begin
        void'($urandom(32'hed81b7c1));
        bd[0] = $urandom_range(32'hcfff);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rc(OFS_STATUS, 32'h90);
        rc(OFS_NCOUNT, 32'h1);
        apb(1'b0, 8'h40, '0);
        chk({31'h0, er}, 32'h1);
        setup(MODE_AFTER, 16'he004);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ba[i], bd[i]);
            rc(OFS_STATUS, 32'hb1);
            apb(1'b1, OFS_STATUS, 32'h20);
        end
        apb(1'b1, OFS_NCOUNT, 32'h1000);
        lv = $urandom_range(32'hfffe, 32'hd000);
        apb(1'b1, OFS_TRANGE, {lv[15:0] + 16'h1, lv[15:0]});
        rc(OFS_STATUS, 32'h91);
        rc(OFS_TRANGE, 32'h2);
        setup(MODE_AFTER, 16'he100);
        rc(OFS_TRANGE, 32'h1);
        rc(OFS_NCOUNT, 32'h1);
        run(200);
        rc(OFS_LEVEL, 32'h0);
        rc(OFS_STATUS, 32'h90);
        setup(MODE_AFTER, 16'he004);
        apb(1'b1, OFS_RCOUNT, 32'h1);
        run(300);
        lv = cnt;
        rc(OFS_LEVEL, 32'(lv));
        rc(OFS_TOFS, 32'h0);
        rc(OFS_RDATA, first);
        rc(OFS_RDATA, 32'h0);
        rc(OFS_TOFS, 32'h1);
        run(100);
        rc(OFS_LEVEL, 32'(lv));
        setup(MODE_BEFORE, 16'he004);
        apb(1'b1, OFS_NCOUNT, 32'h2);
        run(400);
        rc(OFS_LEVEL, 32'd21);
        at_end();
        apb(1'b1, OFS_RCOUNT, 32'h1);
        apb(1'b0, OFS_RDATA, '0);
        chk({15'h0, rd[25], rd[15:0]}, 32'h1e004);
        setup(MODE_BEFORE, 16'hf000);
        run(50);
        at_end();
        setup(MODE_AFTER, 16'he000);
        run(20000);
        rc(OFS_LEVEL, 32'h2000);
        chk({31'h0, cnt < 8200}, 32'h1);
        print_verdict();
    end
endmodule
